// [core/mab_exec.sv]
// Overview of operation
// [RULE1] B bus is local store byte from field one
// [RULE2] A bus is A register ORed with field two
// [RULE3] Opcodes A and B add A and B buses
// [RULE4] Opcodes C and D AND the buses
// [RULE5] Opcodes 8 and 9 OR the buses
// [RULE6] Opcodes E and F exclusive-OR the buses
// [RULE7] Storing forms write D bus into addressed byte
// [RULE8] Test-only odd opcodes leave local store unchanged
// [RULE9] Local store gate opens only when bit 3 clear
// [RULE10] D bus result held until next ALU operation
// [RULE11] A register cleared after every ALU operation
// [RULE12] ALU cycle steps counter and lookahead latches
// [RULE13] Parity sampled on both control word bytes
// [RULE14] Opcodes 2 and 3 are conditional branch
// [RULE15] Field one with bit 3 picks condition
// [RULE16] Met condition loads field two into low byte
// [RULE17] Branch leaves A register unchanged
// [RULE18] Installed feature branch succeeds, forces page four
// [RULE19] Code 20 zero result, 21 no carry
// [RULE20] Codes 30-37 test D bits 0-7
// [RULE21] Code 22 tests partner hardware error
// [RULE22] Codes 28, 29, 38 sense channel tags
// [RULE23] Storing opcodes have bit 3 zero
// [RULE24] Zero and carry held from last result
`timescale 1ns/1ps
`default_nettype none
module mab_exec
    import mab_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [MAB_AW-1:0] paddr_i,
    input wire logic [MAB_DW-1:0] pwdata_i,
    output logic [MAB_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire mab_cond_t cond_i,
    output logic [7:0] d_bus_o,
    output logic [MAB_IC_W-1:0] instruction_sequence_counter_o,
    output logic branch_taken_o,
    output logic parity_error_o
);
    logic pready_ff;
    logic pslverr_ff;
    logic [MAB_DW-1:0] prdata_ff;
    logic [17:0] control_store_word_ff;
    logic exec_ff;
    logic [7:0] a_reg_ff;
    logic [7:0] d_ff;
    logic zero_ff;
    logic carry_ff;
    logic half_select_latch_ff;
    logic dual_channel_feature_flag_ff;
    logic alt_recording_feature_flag_ff;
    logic hi_perr_ff;
    logic lo_perr_ff;
    logic taken_ff;
    logic [MAB_IC_W-1:0] ic_ff;
    logic [MAB_IC_W-1:0] lookahead_ff;
    logic [7:0] local_store_byte_ff [MAB_LS_WORDS];
    mab_cond_t cond_s1_ff;
    mab_cond_t cond_s2_ff;

    logic access;
    logic done_wr;
    mab_reg_t sel;
    logic [4:0] ls_idx;
    logic [3:0] op;
    logic [7:0] field2;
    logic [4:0] ls_addr;
    logic [7:0] b_bus;
    logic [7:0] a_bus;
    logic [8:0] alu_out;
    logic is_alu;
    logic is_boc;
    logic store_gate;
    logic [4:0] cond_idx;
    logic cond_met;
    logic feat_hit;
    logic [MAB_IC_W-1:0] ic_inc;

    function automatic mab_reg_t reg_decode(input logic [MAB_AW-1:0] a);
        mab_reg_t r;
        r = MAB_R_NONE;
        if (a[1:0] != 2'b00) begin
            r = MAB_R_NONE;
        end else if (a >= MAB_OFF_LS && a < MAB_OFF_LS + 12'(4 * MAB_LS_WORDS)) begin
            r = MAB_R_LS;
        end else begin
            case (a)
                MAB_OFF_INSTR: r = MAB_R_INSTR;
                MAB_OFF_AREG: r = MAB_R_AREG;
                MAB_OFF_CTRL: r = MAB_R_CTRL;
                MAB_OFF_STAT: r = MAB_R_STAT;
                MAB_OFF_IC: r = MAB_R_IC;
                default: r = MAB_R_NONE;
            endcase
        end
        return r;
    endfunction

    // Wait state of one cycle keeps prdata and pready both from flops
    assign access = psel_i & penable_i & ~pready_ff;
    assign done_wr = psel_i & penable_i & pready_ff & pwrite_i;
    assign sel = reg_decode(paddr_i);
    assign ls_idx = paddr_i[6:2];

    assign op = control_store_word_ff[MAB_OP_HI:MAB_OP_LO];
    assign field2 = control_store_word_ff[MAB_F2_HI:MAB_F2_LO];
    assign ls_addr = {half_select_latch_ff, control_store_word_ff[MAB_F1_HI:MAB_F1_LO]};
    assign b_bus = local_store_byte_ff[ls_addr]; // [RULE1]
    assign a_bus = a_reg_ff | field2; // [RULE2]
    assign alu_out = mab_alu(op, a_bus, b_bus); // [RULE3] [RULE4] [RULE5] [RULE6]
    assign is_alu = exec_ff & op[3];
    assign is_boc = exec_ff & ({op[3:1], 1'b0} == MAB_OP_BOC); // [RULE14]
    assign store_gate = is_alu & ~control_store_word_ff[MAB_MOD_BIT]; // [RULE9] [RULE23]
    assign cond_idx = {control_store_word_ff[MAB_MOD_BIT], control_store_word_ff[MAB_F1_HI:MAB_F1_LO]}; // [RULE15]
    assign ic_inc = ic_ff + 12'h001;
    assign feat_hit = (cond_idx == MAB_C_FEAT) & (dual_channel_feature_flag_ff | alt_recording_feature_flag_ff);

    always_comb begin
        cond_met = cond_s2_ff.misc_cond[cond_idx];
        if (cond_idx >= MAB_C_DBIT0 && cond_idx <= MAB_C_DBIT7) begin
            cond_met = d_ff[3'h7 - cond_idx[2:0]]; // [RULE20]
        end else begin
            case (cond_idx)
                MAB_C_ZERO: cond_met = zero_ff; // [RULE19]
                MAB_C_NOCARRY: cond_met = ~carry_ff; // [RULE19]
                MAB_C_HWERR: cond_met = cond_s2_ff.partner_hw_error_cond; // [RULE21]
                MAB_C_FEAT: cond_met = feat_hit; // [RULE18]
                MAB_C_DFLCHK: cond_met = cond_s2_ff.dataflow_check_cond;
                MAB_C_ADRTAG: cond_met = cond_s2_ff.address_tag_out_cond; // [RULE22]
                MAB_C_CMDTAG: cond_met = cond_s2_ff.command_tag_out_a | cond_s2_ff.command_tag_out_b; // [RULE22]
                MAB_C_OPTAG: cond_met = cond_s2_ff.operation_tag_in_cond; // [RULE22]
                default: cond_met = cond_s2_ff.misc_cond[cond_idx];
            endcase
        end
    end

    // Condition lines come from other clock domains
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cond_s1_ff <= '0;
            cond_s2_ff <= '0;
        end else begin
            cond_s1_ff <= cond_i;
            cond_s2_ff <= cond_s1_ff;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= access;
            pslverr_ff <= access & (sel == MAB_R_NONE);
            if (access && !pwrite_i) begin
                case (sel)
                    MAB_R_INSTR: prdata_ff <= {14'h0000, control_store_word_ff};
                    MAB_R_AREG: prdata_ff <= {24'h000000, a_reg_ff};
                    MAB_R_CTRL: prdata_ff <= {29'h00000000, alt_recording_feature_flag_ff,
                                              dual_channel_feature_flag_ff, half_select_latch_ff};
                    MAB_R_STAT: prdata_ff <= {19'h00000, taken_ff, lo_perr_ff, hi_perr_ff, carry_ff, zero_ff, d_ff};
                    MAB_R_IC: prdata_ff <= {4'h0, lookahead_ff, 4'h0, ic_ff};
                    MAB_R_LS: prdata_ff <= {24'h000000, local_store_byte_ff[ls_idx]};
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    // A write to the instruction register issues it on the following cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            control_store_word_ff <= MAB_INSTR_RST;
            exec_ff <= 1'b0;
        end else begin
            exec_ff <= done_wr & (sel == MAB_R_INSTR);
            if (done_wr && sel == MAB_R_INSTR) begin
                control_store_word_ff <= pwdata_i[17:0];
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            half_select_latch_ff <= 1'b0;
            dual_channel_feature_flag_ff <= 1'b0;
            alt_recording_feature_flag_ff <= 1'b0;
        end else if (done_wr && sel == MAB_R_CTRL) begin
            half_select_latch_ff <= pwdata_i[MAB_CTRL_HALF];
            dual_channel_feature_flag_ff <= pwdata_i[MAB_CTRL_DUAL];
            alt_recording_feature_flag_ff <= pwdata_i[MAB_CTRL_ALT];
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            a_reg_ff <= 8'h00;
        end else if (is_alu) begin // [RULE17] of executed instructions only ALU operations touch A
            a_reg_ff <= 8'h00; // [RULE11]
        end else if (done_wr && sel == MAB_R_AREG) begin
            a_reg_ff <= pwdata_i[7:0];
        end
    end

    // Branches and idle cycles leave D, zero and carry as they were
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            d_ff <= 8'h00;
            zero_ff <= 1'b0;
            carry_ff <= 1'b0;
        end else if (is_alu) begin
            d_ff <= alu_out[7:0]; // [RULE10]
            zero_ff <= (alu_out[7:0] == 8'h00); // [RULE24]
            carry_ff <= alu_out[8]; // [RULE24]
        end
    end

    always_ff @(posedge clk_i) begin
        if (store_gate) begin
            local_store_byte_ff[ls_addr] <= alu_out[7:0]; // [RULE7] [RULE8]
        end else if (done_wr && sel == MAB_R_LS) begin
            local_store_byte_ff[ls_idx] <= pwdata_i[7:0];
        end
    end

    // Odd parity per byte; the set wins over a same-cycle clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            hi_perr_ff <= 1'b0;
            lo_perr_ff <= 1'b0;
        end else begin
            if (exec_ff && !(^{control_store_word_ff[MAB_PAR_HI], control_store_word_ff[15:8]})) begin
                hi_perr_ff <= 1'b1; // [RULE13]
            end else if (done_wr && sel == MAB_R_STAT && pwdata_i[MAB_ST_HPERR]) begin
                hi_perr_ff <= 1'b0;
            end
            if (exec_ff && !(^{control_store_word_ff[MAB_PAR_LO], control_store_word_ff[7:0]})) begin
                lo_perr_ff <= 1'b1; // [RULE13]
            end else if (done_wr && sel == MAB_R_STAT && pwdata_i[MAB_ST_LPERR]) begin
                lo_perr_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            ic_ff <= MAB_IC_RST;
            lookahead_ff <= MAB_IC_RST;
            taken_ff <= 1'b0;
        end else if (exec_ff) begin
            taken_ff <= is_boc & cond_met;
            lookahead_ff <= ic_inc; // [RULE12]
            if (is_boc && cond_met) begin
                ic_ff[7:0] <= field2; // [RULE16]
                if (feat_hit) begin
                    ic_ff[MAB_IC_W-1:8] <= MAB_FEAT_PAGE; // [RULE18]
                end
            end else begin
                ic_ff <= ic_inc; // [RULE12]
            end
        end else if (done_wr && sel == MAB_R_IC) begin
            ic_ff <= pwdata_i[MAB_IC_W-1:0];
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign d_bus_o = d_ff;
    assign instruction_sequence_counter_o = ic_ff;
    assign branch_taken_o = taken_ff;
    assign parity_error_o = hi_perr_ff | lo_perr_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    AST_ADD_RESULT: assert property (is_alu && op[3:1] == 3'b101 |=> // [RULE3]
        d_ff == 8'($past(a_bus) + $past(b_bus)))
        else $error("add result wrong");
    AST_AND_RESULT: assert property (is_alu && op[3:1] == 3'b110 |=> d_ff == ($past(a_bus) & $past(b_bus))) // [RULE4]
        else $error("and result wrong");
    AST_OR_RESULT: assert property (is_alu && op[3:1] == 3'b100 |=> d_ff == ($past(a_bus) | $past(b_bus))) // [RULE5]
        else $error("or result wrong");
    AST_XOR_RESULT: assert property (is_alu && op[3:1] == 3'b111 |=> d_ff == ($past(a_bus) ^ $past(b_bus))) // [RULE6]
        else $error("xor result wrong");
    AST_STORE: assert property (is_alu && !control_store_word_ff[MAB_MOD_BIT] |=> // [RULE7]
        local_store_byte_ff[$past(ls_addr)] == d_ff)
        else $error("storing form did not write back");
    AST_TEST_ONLY: assert property (is_alu && control_store_word_ff[MAB_MOD_BIT] |=> // [RULE8]
        local_store_byte_ff[$past(ls_addr)] == $past(b_bus))
        else $error("test form changed local store");
    AST_D_HELD: assert property (!is_alu |=> $stable(d_ff) && $stable(zero_ff)) // [RULE10]
        else $error("result changed without an operation");
    AST_A_CLEAR: assert property (is_alu |=> a_reg_ff == 8'h00 ##1 (a_reg_ff == 8'h00 || $past(done_wr))) // [RULE11]
        else $error("A register not cleared");
    AST_IC_STEP: assert property (is_alu |=> ic_ff == $past(ic_inc) && lookahead_ff == ic_ff) // [RULE12]
        else $error("counter not stepped");
    AST_BOC_A: assert property (is_boc |=> $stable(a_reg_ff)) // [RULE17]
        else $error("branch altered A register");
    AST_BOC_TAKEN: assert property (is_boc && cond_met |=> ic_ff[7:0] == $past(field2) && branch_taken_o) // [RULE16]
        else $error("branch target not loaded");
    AST_FEAT_PAGE: assert property (is_boc && feat_hit |=> ic_ff[MAB_IC_W-1:8] == MAB_FEAT_PAGE) // [RULE18]
        else $error("feature branch did not force page");

    // Ready is one cycle wide so read data and error always pair with it
    AST_PREADY_PULSE: assert property (pready_o |=> !pready_o)
        else $error("ready held longer than one cycle");
    AST_SLVERR_QUAL: assert property (pslverr_o |-> pready_o)
        else $error("error reported without ready");
    AST_IDLE_NO_READY: assert property (!psel_i |=> !pready_o)
        else $error("ready without a selected transfer");
    AST_EXEC_SINGLE: assert property (exec_ff |=> !exec_ff)
        else $error("one write issued two executions");

    // Software writes land at the completion edge; in the same cycle any ALU op wins over an A write, a storing one over a local store write
    AST_AREG_WRITE: assert property (done_wr && sel == MAB_R_AREG && !is_alu |=>
        a_reg_ff == $past(pwdata_i[7:0]))
        else $error("A register write lost");
    AST_CTRL_WRITE: assert property (done_wr && sel == MAB_R_CTRL |=>
        half_select_latch_ff == $past(pwdata_i[MAB_CTRL_HALF]))
        else $error("half select write lost");
    AST_LS_WRITE: assert property (done_wr && sel == MAB_R_LS && !store_gate |=>
        local_store_byte_ff[$past(ls_idx)] == $past(pwdata_i[7:0]))
        else $error("local store write lost");

    // Flags that later branches test, then the parity flags and the lookahead latch
    AST_ZERO_FLAG: assert property (is_alu |=> zero_ff == (d_ff == 8'h00)) // [RULE24]
        else $error("zero flag disagrees with result");
    AST_CARRY_LOGIC: assert property (is_alu && op[3:1] != 3'b101 |=> !carry_ff) // [RULE24]
        else $error("logic operation set carry");
    AST_CARRY_ADD: assert property (is_alu && op[3:1] == 3'b101 |=> // [RULE24]
        carry_ff == (({1'b0, $past(a_bus)} + {1'b0, $past(b_bus)}) > 9'h0FF))
        else $error("add carry wrong");
    AST_PARITY_HI: assert property (exec_ff && !(^{control_store_word_ff[MAB_PAR_HI], // [RULE13]
        control_store_word_ff[15:8]}) |=> hi_perr_ff)
        else $error("high byte parity error not flagged");
    AST_PARITY_LO: assert property (exec_ff && !(^{control_store_word_ff[MAB_PAR_LO], // [RULE13]
        control_store_word_ff[7:0]}) |=> lo_perr_ff)
        else $error("low byte parity error not flagged");
    AST_LOOKAHEAD: assert property (exec_ff |=> lookahead_ff == $past(ic_inc)) // [RULE12]
        else $error("lookahead latch not loaded");

    // Branches must not disturb the result that later branches test
    AST_BOC_D_KEPT: assert property (is_boc |=> $stable(d_ff) && $stable(carry_ff)) // [RULE10]
        else $error("branch changed the held result");
    AST_BOC_NOT_TAKEN: assert property (is_boc && !cond_met |=> // [RULE16]
        ic_ff == $past(ic_inc) && !branch_taken_o)
        else $error("failed branch did not step counter");
    AST_BOC_PAGE_KEPT: assert property (is_boc && cond_met && !feat_hit |=> // [RULE16]
        ic_ff[MAB_IC_W-1:8] == $past(ic_ff[MAB_IC_W-1:8]))
        else $error("branch changed the page");
    AST_TAKEN_BOC_ONLY: assert property (exec_ff && !is_boc |=> !branch_taken_o) // [RULE14]
        else $error("taken flag set by a non-branch");
    AST_DBIT_COND: assert property (is_boc && cond_idx == MAB_C_DBIT0 |-> cond_met == d_bus_o[7]) // [RULE20]
        else $error("D bit 0 condition misread");
    AST_FEAT_OFF: assert property (is_boc && cond_idx == MAB_C_FEAT && // [RULE18]
        !dual_channel_feature_flag_ff && !alt_recording_feature_flag_ff |=> !branch_taken_o)
        else $error("feature branch taken without feature");

    COV_ADD_STORE: cover property (is_alu && op == MAB_OP_ADD);
    COV_XOR_TEST: cover property (is_alu && op == MAB_OP_XOR_T);
    COV_BOC_TAKEN: cover property (is_boc && cond_met ##1 is_boc);
    COV_BOC_FEAT: cover property (is_boc && feat_hit);
    COV_PARITY_ERR: cover property (exec_ff ##1 parity_error_o);
endmodule // mab_exec
`default_nettype wire

// [core/mab_pkg.sv]
`default_nettype none
package mab_pkg;
    localparam int MAB_AW = 12;
    localparam int MAB_DW = 32;
    // Register byte offsets on the APB side
    localparam logic [11:0] MAB_OFF_INSTR = 12'h000;
    localparam logic [11:0] MAB_OFF_AREG = 12'h004;
    localparam logic [11:0] MAB_OFF_CTRL = 12'h008;
    localparam logic [11:0] MAB_OFF_STAT = 12'h00C;
    localparam logic [11:0] MAB_OFF_IC = 12'h010;
    localparam logic [11:0] MAB_OFF_LS = 12'h100;
    localparam int MAB_LS_WORDS = 32;
    // Control-store word layout, bit 15 is the MSB of the 16-bit word
    localparam int MAB_OP_HI = 15;
    localparam int MAB_OP_LO = 12;
    localparam int MAB_MOD_BIT = 12;
    localparam int MAB_F1_HI = 11;
    localparam int MAB_F1_LO = 8;
    localparam int MAB_F2_HI = 7;
    localparam int MAB_F2_LO = 0;
    localparam int MAB_PAR_HI = 17;
    localparam int MAB_PAR_LO = 16;
    // Control and status field positions
    localparam int MAB_CTRL_HALF = 0;
    localparam int MAB_CTRL_DUAL = 1;
    localparam int MAB_CTRL_ALT = 2;
    localparam int MAB_ST_ZERO = 8;
    localparam int MAB_ST_CARRY = 9;
    localparam int MAB_ST_HPERR = 10;
    localparam int MAB_ST_LPERR = 11;
    localparam int MAB_ST_TAKEN = 12;
    localparam int MAB_IC_W = 12;
    localparam int MAB_LA_LO = 16;
    // Branch condition indices ({bit 3, field 1})
    localparam logic [4:0] MAB_C_ZERO = 5'h00;
    localparam logic [4:0] MAB_C_NOCARRY = 5'h01;
    localparam logic [4:0] MAB_C_HWERR = 5'h02;
    localparam logic [4:0] MAB_C_FEAT = 5'h03;
    localparam logic [4:0] MAB_C_DFLCHK = 5'h07;
    localparam logic [4:0] MAB_C_ADRTAG = 5'h08;
    localparam logic [4:0] MAB_C_CMDTAG = 5'h09;
    localparam logic [4:0] MAB_C_DBIT0 = 5'h10;
    localparam logic [4:0] MAB_C_DBIT7 = 5'h17;
    localparam logic [4:0] MAB_C_OPTAG = 5'h18;
    localparam logic [3:0] MAB_FEAT_PAGE = 4'h4;
    localparam logic [17:0] MAB_INSTR_RST = 18'h00000;
    localparam logic [11:0] MAB_IC_RST = 12'h000;

    typedef enum logic [3:0] {
        MAB_OP_BOC = 4'h2, MAB_OP_BOC_X = 4'h3, MAB_OP_OR = 4'h8, MAB_OP_OR_T = 4'h9,
        MAB_OP_ADD = 4'hA, MAB_OP_ADD_T = 4'hB, MAB_OP_AND = 4'hC, MAB_OP_AND_T = 4'hD,
        MAB_OP_XOR = 4'hE, MAB_OP_XOR_T = 4'hF
    } mab_op_t;

    typedef enum logic [2:0] {
        MAB_R_NONE = 3'b000, MAB_R_INSTR = 3'b001, MAB_R_AREG = 3'b010, MAB_R_CTRL = 3'b011,
        MAB_R_STAT = 3'b100, MAB_R_IC = 3'b101, MAB_R_LS = 3'b110
    } mab_reg_t;

    typedef struct packed {
        logic partner_hw_error_cond;
        logic dataflow_check_cond;
        logic address_tag_out_cond;
        logic command_tag_out_a;
        logic command_tag_out_b;
        logic operation_tag_in_cond;
        logic [31:0] misc_cond;
    } mab_cond_t;

    // Returns {carry, result}; only the add can carry
    function automatic logic [8:0] mab_alu(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b);
        logic [8:0] r;
        r = 9'h000;
        case (op[3:1])
            3'b101: r = {1'b0, a} + {1'b0, b};
            3'b110: r = {1'b0, a & b};
            3'b100: r = {1'b0, a | b};
            3'b111: r = {1'b0, a ^ b};
            default: r = 9'h000;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// [verification/mab_cond_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mab_cond_model
    import mab_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire mab_cond_t req_i,
    output mab_cond_t cond_o
);
    // Source lines change only on a clock edge, as the sensed logic would
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cond_o <= '0;
        end else begin
            cond_o <= req_i;
        end
    end
endmodule // mab_cond_model
`default_nettype wire

// [verification/micro_alu_branch_exec_test.sv]
`timescale 1ns/1ps
`default_nettype none
module micro_alu_branch_exec_test
    import mab_pkg::*;
;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    mab_cond_t cond_req = '0;
    mab_cond_t cond;
    logic [7:0] d_bus;
    logic [11:0] isc;
    logic taken;
    logic perr;
    int error_cnt = 0;
    int total_checks = 0;
    logic [11:0] exp_ic = 12'h000;
    logic [31:0] rd;
    logic err;
    logic [7:0] ta [8] = '{8'h01, 8'h10, 8'h00, 8'h33, 8'hF0, 8'h0F, 8'h55, 8'hAA};
    logic [7:0] tf [8] = '{8'h02, 8'h20, 8'h80, 8'h44, 8'h0F, 8'hF0, 8'h00, 8'hAA};
    logic [7:0] tb [8] = '{8'h04, 8'h40, 8'h80, 8'h11, 8'hFF, 8'h00, 8'h55, 8'h0F};
    logic [4:0] cx [7] = '{5'h02, 5'h07, 5'h08, 5'h09, 5'h09, 5'h18, 5'h04};
    logic [3:0] op;
    logic [3:0] f1;
    logic hs;
    logic [7:0] ab;
    logic [8:0] r;
    logic [11:0] lsa;

    always #2 clk_i = ~clk_i;

    mab_exec mab_exec_inst (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cond_i(cond), .d_bus_o(d_bus), .instruction_sequence_counter_o(isc),
        .branch_taken_o(taken), .parity_error_o(perr));
    mab_cond_model mab_cond_model_inst (.clk_i(clk_i), .reset_i(reset_i), .req_i(cond_req), .cond_o(cond));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n >= 40) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        chk(nm, e, rd);
        chk({nm, "_err"}, 32'h0, {31'h0, err});
    endtask

    function automatic logic [17:0] wrd(input logic [15:0] w);
        return {~^w[15:8], ~^w[7:0], w};
    endfunction

    // Results land on the edge after the write completes; two edges are waited
    task automatic exec(input logic [17:0] w);
        apb(1'b1, MAB_OFF_INSTR, {14'h0000, w});
        repeat (2) @(posedge clk_i);
    endtask

    task automatic br(input logic [4:0] idx, input logic [7:0] f2, input logic tk, input logic pg4);
        exec(wrd({3'b001, idx, f2}));
        exp_ic = tk ? {(pg4 ? MAB_FEAT_PAGE : exp_ic[11:8]), f2} : exp_ic + 12'h001;
        chk("counter", {20'h00000, exp_ic}, {20'h00000, isc});
        chk("taken", {31'h0, tk}, {31'h0, taken});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        $display("MISMATCH watchdog expected close_out seen timeout");
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        rchk("stat", MAB_OFF_STAT, 32'h00000000);
        rchk("ic", MAB_OFF_IC, 32'h00000000);
        rchk("areg", MAB_OFF_AREG, 32'h00000000);
        rchk("ctrl", MAB_OFF_CTRL, 32'h00000000);
        apb(1'b0, 12'h020, 32'h00000000);
        chk("slverr", 32'h1, {31'h0, err});
        chk("rdata", 32'h0, rd);
        apb(1'b0, 12'h006, 32'h00000000);
        chk("slverr", 32'h1, {31'h0, err});
        $display("test reset and refusal done");
        for (int k = 0; k < 8; k++) begin
            op = 4'h8 + 4'(k);
            f1 = 4'(2 * k + 1);
            hs = 1'(k);
            lsa = MAB_OFF_LS + {5'h00, hs, f1, 2'b00};
            apb(1'b1, lsa, {24'h0, tb[k]});
            apb(1'b1, MAB_OFF_AREG, {24'h0, ta[k]});
            apb(1'b1, MAB_OFF_CTRL, {31'h0, hs});
            exec(wrd({op, f1, tf[k]}));
            ab = ta[k] | tf[k];
            case (op[3:1])
                3'b101: r = {1'b0, ab} + {1'b0, tb[k]};
                3'b110: r = {1'b0, ab & tb[k]};
                3'b100: r = {1'b0, ab | tb[k]};
                default: r = {1'b0, ab ^ tb[k]};
            endcase
            exp_ic = exp_ic + 12'h001;
            chk("d_bus", {24'h0, r[7:0]}, {24'h0, d_bus});
            rchk("stat", MAB_OFF_STAT, {22'h0, r[8], r[7:0] == 8'h00, r[7:0]});
            rchk("ls", lsa, {24'h0, op[0] ? tb[k] : r[7:0]});
            rchk("areg", MAB_OFF_AREG, 32'h00000000);
            rchk("ic", MAB_OFF_IC, {4'h0, exp_ic, 4'h0, exp_ic});
            br(5'h00, 8'hC0 + 8'(k), r[7:0] == 8'h00, 1'b0);
            br(5'h01, 8'hD0 + 8'(k), !r[8], 1'b0);
            br(5'h10 + 5'(k), 8'hE0, r[7 - k], 1'b0);
            chk("d_hold", {24'h0, r[7:0]}, {24'h0, d_bus});
        end
        $display("test alu operations done");
        for (int k = 0; k < 7; k++) begin
            @(posedge clk_i);
            cond_req <= mab_cond_t'(k < 6 ? (38'h1 << (37 - k)) : 38'h10);
            br(cx[k], 8'h30 + 8'(k), 1'b1, 1'b0);
            @(posedge clk_i);
            cond_req <= '0;
            br(cx[k], 8'h40, 1'b0, 1'b0);
        end
        $display("test condition lines done");
        br(MAB_C_FEAT, 8'h50, 1'b0, 1'b0);
        apb(1'b1, MAB_OFF_CTRL, 32'h00000002);
        br(MAB_C_FEAT, 8'h51, 1'b1, 1'b1);
        apb(1'b1, MAB_OFF_CTRL, 32'h00000004);
        br(MAB_C_FEAT, 8'h52, 1'b1, 1'b1);
        apb(1'b1, MAB_OFF_CTRL, 32'h00000000);
        apb(1'b1, MAB_OFF_AREG, 32'h0000003C);
        br(MAB_C_HWERR, 8'h60, 1'b0, 1'b0);
        rchk("areg", MAB_OFF_AREG, 32'h0000003C);
        $display("test feature and branch side effects done");
        exec(wrd(16'h0000) ^ 18'h20000);
        apb(1'b0, MAB_OFF_STAT, 32'h00000000);
        chk("parity_flags", 32'h1, {30'h0, rd[11:10]});
        chk("parity_error", 32'h1, {31'h0, perr});
        apb(1'b1, MAB_OFF_STAT, 32'h00000400);
        exec(wrd(16'h0000) ^ 18'h10000);
        apb(1'b0, MAB_OFF_STAT, 32'h00000000);
        chk("parity_flags", 32'h2, {30'h0, rd[11:10]});
        rchk("instr", MAB_OFF_INSTR, {14'h0000, wrd(16'h0000) ^ 18'h10000});
        $display("test parity done");
        close_out();
    end
endmodule // micro_alu_branch_exec_test
`default_nettype wire
